//--- design/ufp_pkg.sv
// Shared constants, types and helpers of the unicast forwarding pipeline
package ufp_pkg;

  // ----------------------------------------------------------------
  // Datapath geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int BEAT_BYTES = DATA_W / 8;
  localparam int CHUNK_BYTES = 256;
  localparam int CHUNK_BEATS = CHUNK_BYTES / BEAT_BYTES;
  localparam int DESC_BYTES = 64;
  localparam int SLOT_COUNT = 4;
  localparam int SLOT_BEATS = 64;
  localparam int MTU_BEATS = 48;
  localparam int LINKSEC_LAT = 4;
  localparam logic [3:0] FULL_BEAT = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 40;
  localparam int EEE_IDLE_NS = 1000;
  // Least idle time, rounded up to whole cycles
  localparam int EEE_IDLE_CYCLES = (EEE_IDLE_NS * CLOCK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Header field positions in the first beat of a frame
  // ----------------------------------------------------------------
  localparam int HDR_CHIP_LSB = 56;
  localparam int HDR_PORT_LSB = 48;
  localparam int HDR_QOS_LSB = 45;
  localparam int HDR_PRIO_BIT = 44;
  localparam int HDR_MIRROR_BIT = 43;
  localparam int HDR_RECIRC_BIT = 42;
  localparam int HDR_SECURE_BIT = 41;
  localparam int HDR_TTL_LSB = 32;
  localparam logic [7:0] TTL_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic chunk_last;
    logic [3:0] bytes;
    logic [DATA_W-1:0] data;
  } ufp_beat_type;

  // Forwarding fields kept from the frame descriptor
  typedef struct packed {
    logic [7:0] chip;
    logic [7:0] port;
    logic [2:0] qos;
    logic prio;
    logic mirror;
    logic recirc;
    logic secure;
  } ufp_desc_type;

  typedef enum logic [1:0] {
    SLOT_FREE = 2'b00,
    SLOT_FILL = 2'b01,
    SLOT_READY = 2'b11
  } ufp_slot_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_STACK = 2'b01,
    RD_EGRESS = 2'b11
  } ufp_read_state_type;

  localparam ufp_beat_type BEAT_RESET = '0;

  // Header decode, shared by the line and stack ingress paths
  function automatic ufp_desc_type ufp_parse_header(input logic [DATA_W-1:0] hdr);
    ufp_desc_type d;
    d.chip = hdr[HDR_CHIP_LSB +: 8];
    d.port = hdr[HDR_PORT_LSB +: 8];
    d.qos = hdr[HDR_QOS_LSB +: 3];
    d.prio = hdr[HDR_PRIO_BIT];
    d.mirror = hdr[HDR_MIRROR_BIT];
    d.recirc = hdr[HDR_RECIRC_BIT];
    d.secure = hdr[HDR_SECURE_BIT];
    return d;
  endfunction

endpackage

//--- design/ufp_linksec_pipe.sv
// Fixed-latency cut-through link-security pipe
module ufp_linksec_pipe
#(
  parameter int LATENCY = ufp_pkg::LINKSEC_LAT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Beat stream in
  input wire ufp_pkg::ufp_beat_type in_beat,
  input wire logic protect,
  input wire logic [ufp_pkg::DATA_W-1:0] key,
  // Beat stream out
  output ufp_pkg::ufp_beat_type out_beat
);
  import ufp_pkg::*;

  typedef struct packed {
    ufp_beat_type [LATENCY-1:0] stage;
    logic [5:0] index;
  } ufp_lsec_state_type;

  ufp_lsec_state_type state_reg;
  ufp_lsec_state_type state_next;

  // Shift line; the cipher acts on entry so the latency never depends on data
  always_comb
  begin
    logic [5:0] beat_index;
    beat_index = in_beat.sof ? 6'h00 : state_reg.index;
    state_next = state_reg;
    for (int i = LATENCY - 1; i > 0; i--)
    begin
      state_next.stage[i] = state_reg.stage[i - 1];
    end
    state_next.stage[0] = in_beat;
    if (in_beat.valid)
    begin
      state_next.index = in_beat.eof ? 6'h00 : beat_index + 6'h01;
      // Keystream varies per beat so repeated words do not leak
      if (protect)
      begin
        state_next.stage[0].data = in_beat.data ^ key ^ {{(DATA_W - 6){1'b0}}, beat_index};
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign out_beat = state_reg.stage[LATENCY - 1];

endmodule

//--- design/ufp_forwarding_pipeline.sv
// Unicast forwarding pipeline: line ingress, packet store, schedulers, rewrite, egress
module ufp_forwarding_pipeline
#(
  parameter int SLOT_COUNT = ufp_pkg::SLOT_COUNT,
  parameter int SLOT_BEATS = ufp_pkg::SLOT_BEATS,
  parameter int MTU_BEATS = ufp_pkg::MTU_BEATS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Line receive from the PHY
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [3:0] rx_bytes,
  input wire logic [ufp_pkg::DATA_W-1:0] rx_data,
  // Feature control
  input wire logic ptp_enable,
  input wire logic eee_enable,
  input wire logic linksec_rx_enable,
  input wire logic linksec_tx_enable,
  input wire logic [ufp_pkg::DATA_W-1:0] linksec_key,
  input wire logic [7:0] local_chip,
  input wire logic [7:0] mirror_port,
  // Timestamp of received frames
  output logic [31:0] rx_timestamp,
  output logic rx_timestamp_valid,
  // Line transmit to the PHY
  output logic tx_valid,
  output logic tx_sof,
  output logic tx_eof,
  output logic [3:0] tx_bytes,
  output logic [ufp_pkg::DATA_W-1:0] tx_data,
  output logic tx_lpi,
  // Recirculation path
  output logic recirc_valid,
  output logic recirc_sof,
  output logic recirc_eof,
  output logic [3:0] recirc_bytes,
  output logic [ufp_pkg::DATA_W-1:0] recirc_data,
  // Stack transmit
  input wire logic stack_tx_ready,
  output logic stack_tx_valid,
  output logic stack_tx_sof,
  output logic stack_tx_eof,
  output logic [3:0] stack_tx_bytes,
  output logic [ufp_pkg::DATA_W-1:0] stack_tx_data,
  // Stack receive
  input wire logic stack_rx_valid,
  input wire logic stack_rx_sof,
  input wire logic stack_rx_eof,
  input wire logic [3:0] stack_rx_bytes,
  input wire logic [ufp_pkg::DATA_W-1:0] stack_rx_data,
  output logic stack_rx_ready,
  // Status
  output logic [15:0] drop_count
);
  import ufp_pkg::*;

  // ----------------------------------------------------------------
  // Geometry; SLOT_BEATS must be a power of two
  // ----------------------------------------------------------------
  localparam int SW = (SLOT_COUNT > 1) ? $clog2(SLOT_COUNT) : 1;
  localparam int BW = $clog2(SLOT_BEATS);
  localparam int LW = BW + 1;
  localparam int CW = $clog2(CHUNK_BEATS);
  localparam int EW = $clog2(EEE_IDLE_CYCLES + 1);
  localparam int MEM_DEPTH = SLOT_COUNT * SLOT_BEATS;

  typedef struct packed {
    logic [31:0] ts_count;
    logic [31:0] rx_timestamp;
    logic rx_ts_valid;
    logic [CW-1:0] chunk_beat;
    ufp_beat_type chunk;
    logic [1:0] wr_active;
    logic [1:0][SW-1:0] wr_slot;
    logic [1:0][LW-1:0] wr_len;
    logic stack_rx_ready;
    ufp_beat_type [MEM_DEPTH-1:0] mem;
    ufp_slot_state_type [SLOT_COUNT-1:0] slot_state;
    ufp_desc_type [SLOT_COUNT-1:0] slot_desc;
    logic [SLOT_COUNT-1:0][LW-1:0] slot_len;
    logic [SLOT_COUNT-1:0] slot_stack;
    ufp_read_state_type rd_state;
    logic [SW-1:0] rd_slot;
    logic [LW-1:0] rd_idx;
    logic rd_mirror;
    logic last_stack;
    ufp_beat_type stack_tx;
    ufp_desc_type rw_desc;
    logic [LW-1:0] frag_count;
    ufp_beat_type efifo;
    logic efifo_recirc;
    logic efifo_secure;
    ufp_beat_type recirc;
    logic [EW-1:0] idle_count;
    logic lpi;
    logic [15:0] drop_count;
  } ufp_state_type;

  ufp_state_type state_reg;
  ufp_state_type state_next;
  ufp_beat_type lsec_rx_out;
  ufp_beat_type lsec_tx_in;
  ufp_beat_type lsec_tx_out;
  logic lsec_tx_protect;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Flat store address of a beat inside a slot
  function automatic logic [SW+BW-1:0] mem_index(input logic [SW-1:0] slot, input logic [LW-1:0] beat);
    return {slot, beat[BW-1:0]};
  endfunction

  // Lowest slot of the high class, else lowest of the low class; top bit is found
  function automatic logic [SW:0] pick(input logic [SLOT_COUNT-1:0] hi, input logic [SLOT_COUNT-1:0] lo);
    logic [SW-1:0] idx;
    idx = '0;
    for (int i = SLOT_COUNT - 1; i >= 0; i--)
    begin
      if (lo[i])
      begin
        idx = SW'(i);
      end
    end
    for (int i = SLOT_COUNT - 1; i >= 0; i--)
    begin
      if (hi[i])
      begin
        idx = SW'(i);
      end
    end
    return {(|hi) | (|lo), idx};
  endfunction

  // ----------------------------------------------------------------
  // Link-security engines
  // ----------------------------------------------------------------
  ufp_linksec_pipe #(.LATENCY(LINKSEC_LAT)) u_lsec_rx (
    .clock(clock),
    .rst_n(rst_n),
    .in_beat(state_reg.chunk),
    .protect(linksec_rx_enable),
    .key(linksec_key),
    .out_beat(lsec_rx_out)
  );

  assign lsec_tx_in = (state_reg.efifo.valid && !state_reg.efifo_recirc) ? state_reg.efifo : BEAT_RESET;
  assign lsec_tx_protect = state_reg.efifo_secure && linksec_tx_enable;

  ufp_linksec_pipe #(.LATENCY(LINKSEC_LAT)) u_lsec_tx (
    .clock(clock),
    .rst_n(rst_n),
    .in_beat(lsec_tx_in),
    .protect(lsec_tx_protect),
    .key(linksec_key),
    .out_beat(lsec_tx_out)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [CW-1:0] cb;
    ufp_beat_type wbeat [2];
    logic [SLOT_COUNT-1:0] free_mask;
    logic [SLOT_COUNT-1:0] stk_hi, stk_lo, eg_hi, eg_lo;
    logic [SW:0] pk;
    logic [SW:0] spk;
    logic [SW:0] epk;
    logic [SW-1:0] ws;
    logic [LW-1:0] wl;
    logic [LW-1:0] fc;
    logic rd_last;
    logic cut;
    logic [SW:0] free_count;
    ufp_desc_type eg;
    ufp_beat_type beat;
    cb = rx_sof ? '0 : state_reg.chunk_beat;
    wbeat[0] = lsec_rx_out;
    wbeat[1] = BEAT_RESET;
    free_mask = '0;
    stk_hi = '0;
    stk_lo = '0;
    eg_hi = '0;
    eg_lo = '0;
    pk = '0;
    spk = '0;
    epk = '0;
    ws = '0;
    wl = '0;
    fc = '0;
    cut = 1'b0;
    free_count = '0;
    eg = state_reg.rw_desc;
    beat = BEAT_RESET;
    rd_last = (state_reg.rd_idx == state_reg.slot_len[state_reg.rd_slot] - LW'(1));
    state_next = state_reg;

    // Line interface: free-running time base and receive timestamp
    state_next.ts_count = state_reg.ts_count + 32'h1;
    state_next.rx_ts_valid = 1'b0;
    if (rx_valid && rx_sof && ptp_enable)
    begin
      state_next.rx_timestamp = state_reg.ts_count;
      state_next.rx_ts_valid = 1'b1;
    end

    // Line interface: cut the frame into chunks with boundary marks
    state_next.chunk = BEAT_RESET;
    if (rx_valid)
    begin
      state_next.chunk.valid = 1'b1;
      state_next.chunk.sof = rx_sof;
      state_next.chunk.eof = rx_eof;
      state_next.chunk.chunk_last = rx_eof || (cb == CW'(CHUNK_BEATS - 1));
      state_next.chunk.bytes = rx_eof ? rx_bytes : FULL_BEAT;
      state_next.chunk.data = rx_data;
      state_next.chunk_beat = state_next.chunk.chunk_last ? '0 : cb + CW'(1);
    end

    // Store writers: 0 is the line path out of link security, 1 the stack receive port
    if (stack_rx_valid)
    begin
      wbeat[1].valid = 1'b1;
      wbeat[1].sof = stack_rx_sof;
      wbeat[1].eof = stack_rx_eof;
      wbeat[1].chunk_last = stack_rx_eof;
      wbeat[1].bytes = stack_rx_bytes;
      wbeat[1].data = stack_rx_data;
    end
    for (int w = 0; w < 2; w++)
    begin
      for (int i = 0; i < SLOT_COUNT; i++)
      begin
        free_mask[i] = (state_next.slot_state[i] == SLOT_FREE);
      end
      pk = pick('0, free_mask);
      if (wbeat[w].valid && wbeat[w].sof)
      begin
        // A frame whose end went missing is closed at the length of its last complete chunk
        if (state_next.wr_active[w])
        begin
          state_next.slot_state[state_next.wr_slot[w]] = SLOT_READY;
        end
        state_next.wr_active[w] = pk[SW];
        if (pk[SW])
        begin
          state_next.wr_slot[w] = pk[SW-1:0];
          state_next.wr_len[w] = '0;
          state_next.slot_state[pk[SW-1:0]] = SLOT_FILL;
          state_next.slot_len[pk[SW-1:0]] = '0;
          state_next.slot_desc[pk[SW-1:0]] = ufp_parse_header(wbeat[w].data);
          // Remote chip on the line path goes to the stack scheduler, else the egress queues
          state_next.slot_stack[pk[SW-1:0]] = (w == 0) && (wbeat[w].data[HDR_CHIP_LSB +: 8] != local_chip);
        end
        else if (state_next.drop_count != 16'hffff)
        begin
          state_next.drop_count = state_next.drop_count + 16'h1;
        end
      end
      ws = state_next.wr_slot[w];
      wl = state_next.wr_len[w];
      if (wbeat[w].valid && state_next.wr_active[w])
      begin
        // Beats past the slot size are discarded; the reader closes the frame
        if (wl != LW'(SLOT_BEATS))
        begin
          state_next.mem[mem_index(ws, wl)] = wbeat[w];
          state_next.wr_len[w] = wl + LW'(1);
        end
        // Length becomes visible segment by segment
        if (wbeat[w].chunk_last || wbeat[w].eof)
        begin
          state_next.slot_len[ws] = state_next.wr_len[w];
        end
        if (wbeat[w].eof)
        begin
          state_next.slot_state[ws] = SLOT_READY;
          state_next.wr_active[w] = 1'b0;
        end
      end
    end

    // Queue classes built from the slot table
    for (int i = 0; i < SLOT_COUNT; i++)
    begin
      stk_hi[i] = (state_reg.slot_state[i] == SLOT_READY) && state_reg.slot_stack[i] && state_reg.slot_desc[i].prio;
      stk_lo[i] = (state_reg.slot_state[i] == SLOT_READY) && state_reg.slot_stack[i] && !state_reg.slot_desc[i].prio;
      eg_hi[i] = (state_reg.slot_state[i] == SLOT_READY) && !state_reg.slot_stack[i] && state_reg.slot_desc[i].qos[2];
      eg_lo[i] = (state_reg.slot_state[i] == SLOT_READY) && !state_reg.slot_stack[i] && !state_reg.slot_desc[i].qos[2];
    end
    spk = pick(stk_hi, stk_lo);
    epk = pick(eg_hi, eg_lo);

    // Read port of the store, shared by both schedulers
    state_next.stack_tx = BEAT_RESET;
    state_next.efifo = BEAT_RESET;
    case (state_reg.rd_state)
      RD_IDLE:
      begin
        // Alternate when both wait, so neither side starves the other
        if (spk[SW] && stack_tx_ready && (!epk[SW] || !state_reg.last_stack))
        begin
          state_next.rd_state = RD_STACK;
          state_next.rd_slot = spk[SW-1:0];
          state_next.rd_idx = '0;
          state_next.last_stack = 1'b1;
        end
        else if (epk[SW])
        begin
          state_next.rd_state = RD_EGRESS;
          state_next.rd_slot = epk[SW-1:0];
          state_next.rd_idx = '0;
          state_next.rd_mirror = 1'b0;
          state_next.last_stack = 1'b0;
        end
      end
      RD_STACK:
      begin
        beat = state_reg.mem[mem_index(state_reg.rd_slot, state_reg.rd_idx)];
        beat.bytes = (rd_last && !beat.eof) ? FULL_BEAT : beat.bytes;
        beat.eof = rd_last;
        state_next.stack_tx = beat;
        state_next.rd_idx = state_reg.rd_idx + LW'(1);
        if (rd_last)
        begin
          state_next.slot_state[state_reg.rd_slot] = SLOT_FREE;
          state_next.rd_state = RD_IDLE;
        end
      end
      RD_EGRESS:
      begin
        beat = state_reg.mem[mem_index(state_reg.rd_slot, state_reg.rd_idx)];
        if (!beat.eof && rd_last)
        begin
          beat.bytes = FULL_BEAT;
        end
        beat.eof = rd_last;
        // Egress lookup on the first beat: mirror copy, recirculation
        if (state_reg.rd_idx == '0)
        begin
          eg = state_reg.slot_desc[state_reg.rd_slot];
          eg.port = state_reg.rd_mirror ? mirror_port : eg.port;
          eg.recirc = eg.recirc && !state_reg.rd_mirror;
          state_next.rw_desc = eg;
          beat.data[HDR_PORT_LSB +: 8] = eg.port;
          beat.data[HDR_TTL_LSB +: 8] = beat.data[HDR_TTL_LSB +: 8] - TTL_STEP;
        end
        // Fragment after the rewrite at the egress size limit
        fc = (state_reg.rd_idx == '0) ? '0 : state_reg.frag_count;
        cut = (fc == LW'(MTU_BEATS - 1)) && !beat.eof;
        beat.sof = (fc == '0);
        beat.eof = beat.eof || cut;
        beat.bytes = cut ? FULL_BEAT : beat.bytes;
        state_next.frag_count = (cut || beat.eof) ? '0 : fc + LW'(1);
        state_next.efifo = beat;
        state_next.efifo_recirc = eg.recirc;
        state_next.efifo_secure = eg.secure;
        state_next.rd_idx = state_reg.rd_idx + LW'(1);
        if (rd_last)
        begin
          // Replicate once toward the mirror port before releasing the slot
          if (eg.mirror && !state_reg.rd_mirror)
          begin
            state_next.rd_mirror = 1'b1;
            state_next.rd_idx = '0;
          end
          else
          begin
            state_next.slot_state[state_reg.rd_slot] = SLOT_FREE;
            state_next.rd_state = RD_IDLE;
          end
        end
      end
      default:
      begin
        state_next.rd_state = RD_IDLE;
      end
    endcase

    // Stack receive stays open while a frame is in or two slots are free
    for (int i = 0; i < SLOT_COUNT; i++)
    begin
      free_count = free_count + (SW + 1)'(state_next.slot_state[i] == SLOT_FREE);
    end
    state_next.stack_rx_ready = state_next.wr_active[1] || (free_count >= (SW + 1)'(2));

    // Egress FIFO drain: recirculation path here, line path via link security
    state_next.recirc = (state_reg.efifo.valid && state_reg.efifo_recirc) ? state_reg.efifo : BEAT_RESET;

    // Low-power idle after a quiet line, dropped by any transmit beat
    if (lsec_tx_in.valid)
    begin
      state_next.idle_count = '0;
      state_next.lpi = 1'b0;
    end
    else
    begin
      if (state_reg.idle_count != EW'(EEE_IDLE_CYCLES))
      begin
        state_next.idle_count = state_reg.idle_count + EW'(1);
      end
      state_next.lpi = eee_enable && (state_next.idle_count == EW'(EEE_IDLE_CYCLES));
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from registers
  // ----------------------------------------------------------------
  assign rx_timestamp = state_reg.rx_timestamp;
  assign rx_timestamp_valid = state_reg.rx_ts_valid;
  assign tx_valid = lsec_tx_out.valid;
  assign tx_sof = lsec_tx_out.sof;
  assign tx_eof = lsec_tx_out.eof;
  assign tx_bytes = lsec_tx_out.bytes;
  assign tx_data = lsec_tx_out.data;
  assign tx_lpi = state_reg.lpi;
  assign recirc_valid = state_reg.recirc.valid;
  assign recirc_sof = state_reg.recirc.sof;
  assign recirc_eof = state_reg.recirc.eof;
  assign recirc_bytes = state_reg.recirc.bytes;
  assign recirc_data = state_reg.recirc.data;
  assign stack_tx_valid = state_reg.stack_tx.valid;
  assign stack_tx_sof = state_reg.stack_tx.sof;
  assign stack_tx_eof = state_reg.stack_tx.eof;
  assign stack_tx_bytes = state_reg.stack_tx.bytes;
  assign stack_tx_data = state_reg.stack_tx.data;
  assign stack_rx_ready = state_reg.stack_rx_ready;
  assign drop_count = state_reg.drop_count;

endmodule

//--- tb/ufp_properties.sv
// Port checks of the forwarding pipeline
module ufp_properties
#(
  parameter int MTU_BEATS = 48
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Line side
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic ptp_enable,
  input wire logic eee_enable,
  input wire logic rx_timestamp_valid,
  input wire logic tx_valid,
  input wire logic tx_sof,
  input wire logic tx_eof,
  input wire logic [3:0] tx_bytes,
  input wire logic tx_lpi,
  // Stack side and status
  input wire logic stack_tx_ready,
  input wire logic stack_tx_valid,
  input wire logic stack_tx_sof,
  input wire logic stack_tx_eof,
  input wire logic [15:0] drop_count
);
  import ufp_pkg::*;
  logic [7:0] run_reg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Beats of the current line frame; a missed fragment cut shows here
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      run_reg <= 8'h00;
    else if (tx_valid)
      run_reg <= tx_sof ? 8'h01 : run_reg + 8'h01;
  AST_TS: assert property (rx_valid && rx_sof && ptp_enable |=> rx_timestamp_valid) else $error("no stamp");
  AST_TS_CAUSE: assert property (rx_timestamp_valid |-> $past(rx_sof) && $past(rx_valid) && $past(ptp_enable)) else $error("stray stamp");
  AST_LPI: assert property (!eee_enable && !$past(eee_enable) |-> !tx_lpi) else $error("idle while off");
  AST_GRANT: assert property (stack_tx_valid && stack_tx_sof |-> $past(stack_tx_ready, 2) || $past(stack_tx_ready, 3)) else $error("no grant");
  AST_STK_RUN: assert property (stack_tx_valid && !stack_tx_eof |=> stack_tx_valid) else $error("stack gap");
  AST_TX_RUN: assert property (tx_valid && !tx_eof |=> tx_valid) else $error("line gap");
  AST_FULL: assert property (tx_valid && !tx_eof |-> tx_bytes == FULL_BEAT) else $error("short beat");
  AST_LAST: assert property (tx_valid && tx_eof |-> tx_bytes inside {[4'h1:4'h8]}) else $error("bad count");
  AST_FRAG: assert property (tx_valid && !tx_sof |-> run_reg < MTU_BEATS) else $error("long fragment");
  AST_DROP: assert property (drop_count >= $past(drop_count)) else $error("drop count fell");
  cover property (tx_valid && tx_sof);
  cover property (stack_tx_valid && stack_tx_sof);
  cover property ($rose(tx_lpi));
endmodule
bind ufp_forwarding_pipeline ufp_properties #(.MTU_BEATS(MTU_BEATS)) u_ufp_properties (.*);

//--- tb/ufp_stack_peer.sv
// Remote switching chip on the stack link
module ufp_stack_peer
(
  // Clock
  input wire logic clock,
  // Frames from the device
  output logic stack_tx_ready,
  input wire logic stack_tx_valid,
  input wire logic stack_tx_sof,
  // Frames to the device
  output logic stack_rx_valid = 1'b0,
  output logic stack_rx_sof = 1'b0,
  output logic stack_rx_eof = 1'b0,
  output logic [3:0] stack_rx_bytes = 4'h8,
  output logic [63:0] stack_rx_data = 64'h0,
  input wire logic stack_rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic open = 1'b1;
  int nf = 0;
  int nb = 0;
  // Room is granted by the bench, so a slow remote chip can be shown
  assign stack_tx_ready = open;
  // Frames seen and beats of the last one
  always @(posedge clock)
    if (stack_tx_valid)
    begin
      nb <= stack_tx_sof ? 1 : nb + 1;
      nf <= nf + int'(stack_tx_sof);
    end
  // Start only while the device has room; idle data keeps moving
  task automatic send(input logic [63:0] h, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      while (i == 0 && stack_rx_ready !== 1'b1)
        @(negedge clock);
      stack_rx_valid = 1'b1;
      stack_rx_sof = i == 0;
      stack_rx_eof = i == n - 1;
      stack_rx_data = i == 0 ? h : 64'h0123_4567_89ab_cdef ^ 64'(i);
    end
    @(negedge clock);
    stack_rx_valid = 1'b0;
    stack_rx_data = ~stack_rx_data;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench of the forwarding pipeline
module tb import ufp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, rx_valid = 0, rx_sof = 0, rx_eof = 0, ptp_enable = 0, eee_enable = 0;
  logic linksec_rx_enable = 0, linksec_tx_enable = 0, stack_tx_ready, stack_rx_valid, stack_rx_sof;
  logic stack_rx_eof, stack_rx_ready, rx_timestamp_valid, tx_valid, tx_sof, tx_eof, tx_lpi;
  logic recirc_valid, recirc_sof, recirc_eof, stack_tx_valid, stack_tx_sof, stack_tx_eof;
  logic [3:0] rx_bytes = 4'h8, tx_bytes, recirc_bytes, stack_tx_bytes, stack_rx_bytes, lb;
  logic [7:0] local_chip = 8'h01, mirror_port = 8'h2a;
  logic [15:0] drop_count;
  logic [31:0] rx_timestamp;
  logic [63:0] rx_data = '0, tx_data, recirc_data, stack_tx_data, stack_rx_data, h0, d1;
  logic [63:0] linksec_key = 64'h5a5a_0f0f_3c3c_9696;
  localparam logic [63:0] PAY = 64'h0123_4567_89ab_cdef;
  int errors = 0, comparisons = 0, ns = 0, nb = 0, rs = 0, cyc = 0, ts0 = 0;
  ufp_forwarding_pipeline u_ufp_forwarding_pipeline (.*);
  ufp_stack_peer u_ufp_stack_peer (.*);
  always #12.5 clock = ~clock;
  // Tally line frames; the last frame's length and header stay for checks
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (rx_valid && rx_sof)
      ts0 <= cyc;
    if (tx_valid)
      nb <= tx_sof ? 1 : nb + 1;
    if (tx_valid && tx_sof)
      h0 <= tx_data;
    if (tx_valid && nb == 1)
      d1 <= tx_data;
    if (tx_valid && tx_eof)
      lb <= tx_bytes;
    ns <= ns + int'(tx_valid && tx_sof);
    rs <= rs + int'(recirc_valid && recirc_sof);
  end
  // A hang ends the run well past the longest test
  always @(negedge clock)
    if (cyc == 6000)
    begin
      errors++;
      final_report();
    end
  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] hd(input logic [7:0] chip, input logic [7:0] flags);
    return {chip, 8'h05, flags, 8'h10, 32'h0};
  endfunction
  // Wait until k frames have left and every output is quiet
  task automatic wt(input int k);
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clock);
      if (ns + rs + u_ufp_stack_peer.nf >= k && !tx_valid && !recirc_valid && !stack_tx_valid)
        return;
    end
    chk(0, 1);
  endtask
  // PHY beats cannot stall: the frame goes out back to back
  task automatic send(input logic [63:0] h, input int n, input logic [3:0] b);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      rx_valid = 1;
      rx_sof = i == 0;
      rx_eof = i == n - 1;
      rx_bytes = i == n - 1 ? b : 4'h8;
      rx_data = i == 0 ? h : PAY ^ 64'(i);
    end
    @(negedge clock);
    rx_valid = 0;
    rx_data = ~rx_data;
  endtask
  task automatic run(input logic [63:0] h, input int n, input logic [3:0] b, input int add);
    int k;
    k = ns + rs + u_ufp_stack_peer.nf + add;
    send(h, n, b);
    wt(k);
  endtask
  task automatic t_line;
    int s;
    ptp_enable = 1;
    run(hd(8'h01, 8'h00), 3, 4'h5, 1);
    ptp_enable = 0;
    chk(nb, 3);
    chk(lb, 4'h5);
    // Time base starts at the first edge after the three reset cycles
    chk(rx_timestamp, ts0 - 3);
    chk(h0[39:32], 8'h0f);
    chk(h0[55:48], 8'h05);
    run(hd(8'h01, 8'h08), 2, 4'h8, 2);
    chk(h0[55:48], mirror_port);
    s = ns;
    run(hd(8'h01, 8'h04), 2, 4'h8, 1);
    chk(ns, s);
    run(hd(8'h01, 8'h00), 50, 4'h3, 2);
    chk(nb, 2);
    chk(lb, 4'h3);
    // Ciphered header must be restored before the lookup, else it leaves on the stack
    linksec_rx_enable = 1;
    run(hd(8'h01, 8'h00) ^ linksec_key, 2, 4'h8, 1);
    linksec_rx_enable = 0;
    chk(h0[55:48], 8'h05);
    linksec_tx_enable = 1;
    run(hd(8'h01, 8'h02), 2, 4'h8, 1);
    linksec_tx_enable = 0;
    chk(d1, PAY ^ linksec_key);
    $display("line tests done");
  endtask
  task automatic t_stack;
    int n;
    n = u_ufp_stack_peer.nf;
    u_ufp_stack_peer.open = 0;
    // Five frames for four slots: the fifth finds no room and is dropped and counted
    repeat (5) send(hd(8'h07, 8'h10), 4, 4'h8);
    repeat (30) @(negedge clock);
    chk(u_ufp_stack_peer.nf, n);
    u_ufp_stack_peer.open = 1;
    wt(ns + rs + n + 4);
    chk(u_ufp_stack_peer.nb, 4);
    chk(drop_count, 16'h0001);
    n = ns + rs + u_ufp_stack_peer.nf + 1;
    u_ufp_stack_peer.send(hd(8'h07, 8'h00), 3);
    wt(n);
    chk(nb, 3);
    eee_enable = 1;
    repeat (50) @(negedge clock);
    chk(tx_lpi, 1);
    $display("stack and idle tests done");
  endtask
  initial
  begin
    repeat (3) @(negedge clock);
    rst_n = 1;
    t_line();
    t_stack();
    final_report();
  end
endmodule
